//--- core/srsc_cfg.svh
/*
 * constants for the speed ramp and stop control block: register offsets,
 * field positions, reset values and timing counts.
 * assumes inclusion by bare name from files on the core/ include path.
 */
`ifndef SRSC_CFG_SVH
`define SRSC_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SRSC_OFF_CTRL 8'h00
`define SRSC_OFF_PANEL 8'h04
`define SRSC_OFF_ULIM 8'h08
`define SRSC_OFF_ACC 8'h0C
`define SRSC_OFF_DEC 8'h10
`define SRSC_OFF_WAIT 8'h14
`define SRSC_OFF_STAT 8'h18
`define SRSC_OFF_SEG 8'h1C

// ----------------------------------------------------------------------
// control and digit-select field positions
// ----------------------------------------------------------------------
`define SRSC_CTRL_RUN 0
`define SRSC_CTRL_PANEL 1
`define SRSC_CTRL_STOP 2
`define SRSC_CTRL_ASHP 4
`define SRSC_CTRL_DSHP 6
`define SRSC_SEG_ALTZ 4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SRSC_RST_CTRL 8'h00
`define SRSC_RST_PANEL 12'h000
`define SRSC_RST_ULIM 12'hBB8
`define SRSC_RST_RAMP 16'h001E
`define SRSC_RST_WAIT 16'h0064

// ----------------------------------------------------------------------
// timing: ramp time unit 0.01 s, one speed unit 1 r/min per 1000 r/min
// ----------------------------------------------------------------------
`define SRSC_CLK_PS 4000
`define SRSC_TICK_PS 10000000
`define SRSC_TICK_CYC ((`SRSC_TICK_PS + `SRSC_CLK_PS - 1) / `SRSC_CLK_PS)
`define SRSC_UNIT_TICKS 1000
`define SRSC_RES_FINE 16'd300
`define SRSC_RES_MID 16'd3000
`define SRSC_S1_BAND 12'd250
`define SRSC_S2_BAND 12'd500

`endif

//--- core/srsc_pkg.sv
/*
 * types for the speed ramp and stop control block.
 * assumes srsc_cfg.svh holds all numeric constants.
 */
package srsc_pkg;

   // ramp shaping choices
   typedef enum logic [1:0] {SRSC_LINEAR, SRSC_SCURVE1, SRSC_SCURVE2} srsc_shape_t;

   // stop sequencing states
   typedef enum logic [1:0] {SRSC_OFF, SRSC_RUN, SRSC_DECEL, SRSC_HOLD} srsc_state_t;

endpackage : srsc_pkg

//--- core/srsc_step_if.sv
/*
 * carrier between the ramp control and its step pacer.
 * assumes both ends share aclk.
 */
`timescale 1ns/1ps
`default_nettype none

interface srsc_step_if;
   logic active; // ramp still moving
   srsc_pkg::srsc_shape_t shape; // shape of current ramp
   logic [15:0] ramp_time; // 0.01 s per 1000 r/min
   logic [11:0] dist_start; // distance from ramp start
   logic [11:0] dist_end; // distance to goal
   logic step; // one r/min step pulse
   logic tick; // 10 us timebase pulse

   modport pacer (input active, shape, ramp_time, dist_start, dist_end, output step, tick);
   modport ramp (output active, shape, ramp_time, dist_start, dist_end, input step, tick);
endinterface : srsc_step_if

`default_nettype wire

//--- core/srsc_step_pacer.sv
/*
 * step pacer: 10 us timebase and one speed step every ramp_time ticks,
 * stretched near both ramp ends for the s-curve shapes.
 * assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "srsc_cfg.svh"

module srsc_step_pacer
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // ramp side
   srsc_step_if.pacer s
);

   logic [11:0] pre_r; // timebase prescaler
   logic [17:0] cnt_r; // ticks since last step
   logic [17:0] period; // ticks per step
   logic [1:0] mult; // curve stretch exponent
   logic near; // within the softening band

   // ----------------------------------------------------------------------
   // timebase
   // ----------------------------------------------------------------------
   // 10 us tick from the core clock
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pre_r <= 12'h000;
         s.tick <= 1'b0;
      end
      else if (pre_r == 12'(`SRSC_TICK_CYC - 1))
      begin
         pre_r <= 12'h000;
         s.tick <= 1'b1;
      end
      else
      begin
         pre_r <= pre_r + 12'h001;
         s.tick <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // shaping
   // ----------------------------------------------------------------------
   // stretch factor: linear none, s1 x2 in 250 band, s2 x4 in 500 band
   always_comb
   begin
      near = 1'b0;
      mult = 2'd0;
      unique case (s.shape)
         srsc_pkg::SRSC_LINEAR: mult = 2'd0; // constant rate
         srsc_pkg::SRSC_SCURVE1:
         begin
            near = (s.dist_start < `SRSC_S1_BAND) || (s.dist_end < `SRSC_S1_BAND);
            mult = near ? 2'd1 : 2'd0; // soft start and end
         end
         default:
         begin
            near = (s.dist_start < `SRSC_S2_BAND) || (s.dist_end < `SRSC_S2_BAND);
            mult = near ? 2'd2 : 2'd0; // stronger curvature
         end
      endcase
      // 1 r/min per ramp_time ticks gives 1000 r/min per ramp_time x 0.01 s
      period = {2'b00, (s.ramp_time == 16'h0000) ? 16'h0001 : s.ramp_time} << mult;
   end

   // ----------------------------------------------------------------------
   // step pulse
   // ----------------------------------------------------------------------
   // count ticks, fire one step when the period is reached
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !s.active)
      begin
         cnt_r <= 18'h00000;
         s.step <= 1'b0;
      end
      else if (s.tick && (cnt_r + 18'h00001 >= period))
      begin
         cnt_r <= 18'h00000;
         s.step <= 1'b1;
      end
      else
      begin
         cnt_r <= s.tick ? cnt_r + 18'h00001 : cnt_r;
         s.step <= 1'b0;
      end
   end

endmodule : srsc_step_pacer

`default_nettype wire

//--- core/srsc_top.sv
/*
 * speed ramp and stop control: axi4-lite register file, target selection
 * and clamp, ramped speed command, coast or ramp-down stop with zero hold,
 * and a 7-segment digit encoder.
 * assumes ext_target comes from logic on aclk; outputs feed the power
 * stage and velocity loop on the same clock.
 */
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "srsc_cfg.svh"

// Notes on behaviour
// - panel speed is target only in panel source
// - internal target never exceeds upper limit
// - accel time means time per 1000 r/min
// - decel time means time per 1000 r/min
// - ramp times quantised 0.01/0.1/1 s by range
// - separate accel and decel shape selection
// - linear shape: constant rate, default
// - s-curve one softens ramp start and end
// - s-curve two curves harder than one
// - coast stop cuts power at once
// - ramp stop decelerates to zero first
// - zero speed held electrically after ramp
// - waiting time over: cut power, coast
// - digit zero has two glyph forms
module srsc_top
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // external speed source
   input wire logic [11:0] ext_target,
   // drive outputs
   output logic [11:0] speed_cmd_r,
   output logic power_en_r,
   output logic zero_hold_r,
   output logic coasting_r,
   // keypad digit glyph
   output logic [6:0] seg_r
);

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   // merge write data into a register under byte strobes
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : wmerge

   // snap a ramp time to the resolution of its range
   function automatic logic [15:0] quant(input logic [15:0] t);
      if (t < `SRSC_RES_FINE)
      begin
         return t; // 0.01 s steps
      end
      else if (t < `SRSC_RES_MID)
      begin
         return t - (t % 16'd10); // 0.1 s steps
      end
      return t - (t % 16'd100); // 1 s steps
   endfunction : quant

   // decimal digit to segments gfedcba, zero in two forms
   function automatic logic [6:0] glyph(input logic [3:0] d, input logic alt);
      unique case (d)
         4'h0: return alt ? 7'h5C : 7'h3F; // small or full zero
         4'h1: return 7'h06;
         4'h2: return 7'h5B;
         4'h3: return 7'h4F;
         4'h4: return 7'h66;
         4'h5: return 7'h6D;
         4'h6: return 7'h7D;
         4'h7: return 7'h07;
         4'h8: return 7'h7F;
         4'h9: return 7'h6F;
         default: return 7'h00;
      endcase
   endfunction : glyph

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   logic [7:0] ctrl_r; // run, source, stop mode, shapes
   logic [11:0] panel_r; // stored internal speed
   logic [11:0] ulim_r; // upper speed limit
   logic [15:0] acc_r; // accel time, 0.01 s units
   logic [15:0] dec_r; // decel time, 0.01 s units
   logic [15:0] wait_r; // free-run waiting time, 0.01 s units
   logic [4:0] segsel_r; // digit and zero form
   logic [7:0] awaddr_r; // latched write address
   logic [31:0] wdata_r; // latched write data
   logic [3:0] wstrb_r; // latched strobes
   logic aw_got_r; // address held
   logic w_got_r; // data held
   logic wr_fire; // both halves present
   logic wr_ok; // write address mapped
   logic [31:0] rd_data; // read mux
   logic rd_ok; // read address mapped
   srsc_pkg::srsc_state_t state_r; // stop sequence state
   logic [9:0] sub_r; // ticks inside one 0.01 s unit
   logic [15:0] units_r; // hold units elapsed
   logic [11:0] target; // clamped selected target
   logic [11:0] goal; // where the ramp heads
   logic [11:0] goal_prev_r; // goal seen last cycle
   logic [11:0] start_r; // speed where ramp began
   logic run; // run command bit
   srsc_step_if st ();

   // ----------------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------------
   assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
   assign wr_ok = (awaddr_r[1:0] == 2'b00) && (awaddr_r <= `SRSC_OFF_SEG);

   // take address and data in either order, answer once both held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_r <= s_axi_awaddr;
            aw_got_r <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            w_got_r <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10; // unmapped gives slverr
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------
   // software writes; status offset is read-only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r <= `SRSC_RST_CTRL;
         panel_r <= `SRSC_RST_PANEL;
         ulim_r <= `SRSC_RST_ULIM;
         acc_r <= `SRSC_RST_RAMP;
         dec_r <= `SRSC_RST_RAMP;
         wait_r <= `SRSC_RST_WAIT;
         segsel_r <= 5'h00;
      end
      else if (wr_fire && wr_ok)
      begin
         unique case (awaddr_r)
            `SRSC_OFF_CTRL: ctrl_r <= 8'(wmerge({24'h0, ctrl_r}, wdata_r, wstrb_r));
            `SRSC_OFF_PANEL: panel_r <= 12'(wmerge({20'h0, panel_r}, wdata_r, wstrb_r));
            `SRSC_OFF_ULIM: ulim_r <= 12'(wmerge({20'h0, ulim_r}, wdata_r, wstrb_r));
            `SRSC_OFF_ACC: acc_r <= quant(16'(wmerge({16'h0, acc_r}, wdata_r, wstrb_r)));
            `SRSC_OFF_DEC: dec_r <= quant(16'(wmerge({16'h0, dec_r}, wdata_r, wstrb_r)));
            `SRSC_OFF_WAIT: wait_r <= 16'(wmerge({16'h0, wait_r}, wdata_r, wstrb_r));
            `SRSC_OFF_SEG: segsel_r <= 5'(wmerge({27'h0, segsel_r}, wdata_r, wstrb_r));
            default: ctrl_r <= ctrl_r; // status: writes ignored
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------------
   // read mux, unused bits read zero
   always_comb
   begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         `SRSC_OFF_CTRL: rd_data = {24'h0, ctrl_r};
         `SRSC_OFF_PANEL: rd_data = {20'h0, panel_r};
         `SRSC_OFF_ULIM: rd_data = {20'h0, ulim_r};
         `SRSC_OFF_ACC: rd_data = {16'h0, acc_r};
         `SRSC_OFF_DEC: rd_data = {16'h0, dec_r};
         `SRSC_OFF_WAIT: rd_data = {16'h0, wait_r};
         `SRSC_OFF_STAT: rd_data = {12'h0, coasting_r, zero_hold_r, power_en_r, 1'b0,
                                    2'b00, state_r, speed_cmd_r};
         `SRSC_OFF_SEG: rd_data = {20'h0, 1'b0, seg_r, 4'h0} | {27'h0, segsel_r};
         default:
         begin
            rd_data = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
   end

   // one read at a time, data registered with the answer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // target selection
   // ----------------------------------------------------------------------
   assign run = ctrl_r[`SRSC_CTRL_RUN];

   // panel speed only when panel is the source, then clamp
   always_comb
   begin
      target = ctrl_r[`SRSC_CTRL_PANEL] ? panel_r : ext_target;
      if (target > ulim_r)
      begin
         target = ulim_r;
      end
      goal = (state_r == srsc_pkg::SRSC_RUN) ? target : 12'h000;
   end

   // ----------------------------------------------------------------------
   // stop sequence
   // ----------------------------------------------------------------------
   // coast, run, ramp down, zero hold
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r <= srsc_pkg::SRSC_OFF;
         sub_r <= 10'h000;
         units_r <= 16'h0000;
      end
      else
      begin
         unique case (state_r)
            srsc_pkg::SRSC_OFF:
            begin
               if (run)
               begin
                  state_r <= srsc_pkg::SRSC_RUN;
               end
            end
            srsc_pkg::SRSC_RUN:
            begin
               if (!run && !ctrl_r[`SRSC_CTRL_STOP])
               begin
                  state_r <= srsc_pkg::SRSC_OFF; // free stop
               end
               else if (!run)
               begin
                  state_r <= srsc_pkg::SRSC_DECEL; // ramp_down_stop
               end
            end
            srsc_pkg::SRSC_DECEL:
            begin
               sub_r <= 10'h000;
               units_r <= 16'h0000;
               if (run)
               begin
                  state_r <= srsc_pkg::SRSC_RUN;
               end
               else if (speed_cmd_r == 12'h000)
               begin
                  state_r <= srsc_pkg::SRSC_HOLD; // zero reached, lock
               end
            end
            srsc_pkg::SRSC_HOLD:
            begin
               if (run)
               begin
                  state_r <= srsc_pkg::SRSC_RUN;
               end
               else if (units_r >= wait_r)
               begin
                  state_r <= srsc_pkg::SRSC_OFF; // waiting over, coast
               end
               else if (st.tick)
               begin
                  sub_r <= (sub_r == 10'(`SRSC_UNIT_TICKS - 1)) ? 10'h000 : sub_r + 10'h001;
                  units_r <= (sub_r == 10'(`SRSC_UNIT_TICKS - 1)) ? units_r + 16'h0001 : units_r;
               end
            end
         endcase
      end
   end

   // drive status outputs follow the state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         power_en_r <= 1'b0;
         zero_hold_r <= 1'b0;
         coasting_r <= 1'b1;
      end
      else
      begin
         power_en_r <= (state_r != srsc_pkg::SRSC_OFF);
         zero_hold_r <= (state_r == srsc_pkg::SRSC_HOLD);
         coasting_r <= (state_r == srsc_pkg::SRSC_OFF);
      end
   end

   // ----------------------------------------------------------------------
   // ramp generator
   // ----------------------------------------------------------------------
   // accel or decel settings chosen by direction of travel
   always_comb
   begin
      st.active = (speed_cmd_r != goal) && (state_r != srsc_pkg::SRSC_OFF);
      st.ramp_time = (goal > speed_cmd_r) ? acc_r : dec_r;
      st.shape = srsc_pkg::srsc_shape_t'((goal > speed_cmd_r) ? ctrl_r[`SRSC_CTRL_ASHP +: 2]
                                                               : ctrl_r[`SRSC_CTRL_DSHP +: 2]);
      st.dist_start = (speed_cmd_r > start_r) ? speed_cmd_r - start_r : start_r - speed_cmd_r;
      st.dist_end = (speed_cmd_r > goal) ? speed_cmd_r - goal : goal - speed_cmd_r;
   end

   // step toward goal, stop on it, zero when coasting
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         speed_cmd_r <= 12'h000;
         start_r <= 12'h000;
         goal_prev_r <= 12'h000;
      end
      else
      begin
         goal_prev_r <= goal;
         if (goal != goal_prev_r)
         begin
            start_r <= speed_cmd_r; // new ramp begins here
         end
         if (state_r == srsc_pkg::SRSC_OFF)
         begin
            speed_cmd_r <= 12'h000; // no control while coasting
         end
         else if (speed_cmd_r == goal)
         begin
            speed_cmd_r <= speed_cmd_r; // hold at target
         end
         else if (st.step)
         begin
            speed_cmd_r <= (goal > speed_cmd_r) ? speed_cmd_r + 12'h001
                                                : speed_cmd_r - 12'h001;
         end
      end
   end

   // step pacing and shaping
   srsc_step_pacer u_pacer
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .s(st.pacer)
   );

   // ----------------------------------------------------------------------
   // keypad digit
   // ----------------------------------------------------------------------
   // registered glyph of the selected digit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         seg_r <= 7'h00;
      end
      else
      begin
         seg_r <= glyph(segsel_r[3:0], segsel_r[`SRSC_SEG_ALTZ]);
      end
   end

endmodule : srsc_top

`default_nettype wire

//--- verif/srsc_motor_model.sv
/* motor model: shaft follows the command while powered, runs down after.
   assumes drive outputs on aclk. */
`timescale 1ns/1ps
`default_nettype none
module srsc_motor_model
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // drive side
   input wire logic [11:0] speed_cmd_r,
   input wire logic power_en_r,
   // shaft
   output logic [11:0] motor_speed
);
   // follows command under power, loses 1 r/min a cycle unpowered
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         motor_speed <= 12'h000;
      else if (power_en_r)
         motor_speed <= speed_cmd_r;
      else if (motor_speed != 12'h000)
         motor_speed <= motor_speed - 12'h001;
   end
endmodule : srsc_motor_model
`default_nettype wire

//--- verif/srsc_top_asserts.sv
/* checker: bus handshakes and drive relations of srsc_top.
   assumes bind onto srsc_top, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module srsc_top_asserts
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // drive
   input wire logic [11:0] speed_cmd_r,
   input wire logic power_en_r,
   input wire logic zero_hold_r,
   input wire logic coasting_r
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_coast_zero: assert property (coasting_r |-> speed_cmd_r == 12'h000)
      else $error("speed not zero while coasting");
   chk_hold_zero: assert property (zero_hold_r |-> speed_cmd_r == 12'h000 && power_en_r)
      else $error("zero hold without zero speed or power");
   chk_step_gap: assert property (!coasting_r && $changed(speed_cmd_r)
      |=> ($stable(speed_cmd_r) || coasting_r)[*8]) else $error("speed stepped too fast");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   // main scenarios
   cov_hold: cover property (zero_hold_r);
   cov_coast: cover property ($rose(coasting_r));
   cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule : srsc_top_asserts
bind srsc_top srsc_top_asserts u_srsc_top_asserts (.*);
`default_nettype wire

//--- verif/speed_ramp_stop_control_test.sv
/* testbench: register access, ramps, stops and digit glyphs of srsc_top.
   assumes the motor model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module speed_ramp_stop_control_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [11:0] ext_target = 12'h002;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [11:0] speed_cmd_r, motor_speed;
   logic power_en_r, zero_hold_r, coasting_r;
   logic [6:0] seg_r;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   srsc_top u_srsc_top (.*);
   srsc_motor_model u_srsc_motor_model (.aclk, .aresetn, .speed_cmd_r, .power_en_r,
      .motor_speed);
   initial
   begin
      forever #2 aclk = ~aclk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // one comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // write: aw and w offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) s_axi_bready <= !s_axi_bready;
      end while (!(s_axi_bvalid && s_axi_bready));
      chk(s_axi_bresp, r);
   endtask : wr
   // read one word
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'b00);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) s_axi_rready <= !s_axi_rready;
      end while (!(s_axi_rvalid && s_axi_rready));
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask : idle
   // hang guard
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 95000)
      begin
         mismatches++;
         finish_test();
      end
   end
   initial
   begin
      int n;
      n = 0;
      idle(3);
      aresetn <= 1'b1;
      idle(1);
      rd(8'h08, 32'h0000_0BB8);
      rd(8'h0C, 32'h0000_001E);
      rd(8'h20, 32'h0, 2'b10);
      wr(8'h24, 32'h1, 2'b10);
      wr(8'h0C, 32'h131);
      rd(8'h0C, 32'h12C);
      wr(8'h10, 32'hBEF);
      rd(8'h10, 32'hBB8);
      wr(8'h0C, 32'h1D);
      rd(8'h0C, 32'h1D);
      wr(8'h0C, 32'h1);
      wr(8'h10, 32'h1);
      wr(8'h14, 32'h0);
      wr(8'h08, 32'h3);
      wr(8'h04, 32'h5);
      wr(8'h00, 32'h7);
      idle(10000);
      chk(speed_cmd_r, 32'h3);
      idle(5000);
      rd(8'h18, 32'h21003);
      wr(8'h00, 32'h5);
      idle(4000);
      chk(speed_cmd_r, 32'h2);
      wr(8'h08, 32'h4);
      wr(8'h00, 32'h15);
      ext_target <= 12'h004;
      idle(6000);
      chk(speed_cmd_r, 32'h3);
      idle(6000);
      chk(speed_cmd_r, 32'h4);
      wr(8'h00, 32'h85);
      ext_target <= 12'h002;
      idle(15000);
      chk(speed_cmd_r, 32'h3);
      idle(12000);
      chk(speed_cmd_r, 32'h2);
      wr(8'h00, 32'h5);
      wr(8'h00, 32'h4);
      while (zero_hold_r !== 1'b1 && n < 8000)
      begin
         @(posedge aclk);
         n++;
      end
      chk(zero_hold_r, 32'h1);
      chk(power_en_r, 32'h1);
      chk(motor_speed, 32'h0);
      idle(4);
      chk(coasting_r, 32'h1);
      chk(power_en_r, 32'h0);
      wr(8'h00, 32'h1);
      idle(6000);
      chk(power_en_r, 32'h1);
      wr(8'h00, 32'h0);
      idle(3);
      chk(power_en_r, 32'h0);
      chk(speed_cmd_r, 32'h0);
      wr(8'h1C, 32'h10);
      idle(3);
      chk(seg_r, 32'h5C);
      wr(8'h1C, 32'h0);
      idle(3);
      chk(seg_r, 32'h3F);
      finish_test();
   end
endmodule : speed_ramp_stop_control_test
`default_nettype wire
